// *** sense_ctrl_pkg.sv ***
package sense_ctrl_pkg;

    // ------------------------------------------------------------
    // register map
    // ------------------------------------------------------------
    localparam logic [7:0] CTRL_ADDR       = 8'h10;
    localparam logic [7:0] CTRL_RESET      = 8'h00;
    localparam logic [7:0] CAL_MODE_RESET  = 8'h00;
    localparam logic [7:0] GATE_CUR_RESET  = 8'h00;

    // ------------------------------------------------------------
    // field positions
    // ------------------------------------------------------------
    localparam int CAL_A_BIT   = 0;
    localparam int CAL_B_BIT   = 1;
    localparam int CAL_C_BIT   = 2;
    localparam int SEN_A_BIT   = 3;
    localparam int SEN_B_BIT   = 4;
    localparam int SEN_C_BIT   = 5;
    localparam int PHASES      = 3;

    // ------------------------------------------------------------
    // timing
    // ------------------------------------------------------------
    localparam int CLK_HZ          = 50_000_000;
    localparam int DRIVE_WINDOW_NS = 4000;
    localparam int DRIVE_WINDOW_CYC = (DRIVE_WINDOW_NS * (CLK_HZ / 1_000_000)) / 1000;
    localparam int AUTO_CAL_CYC    = 100;

    // ------------------------------------------------------------
    // amplifier mode
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        AMP_NORMAL     = 2'b00,
        AMP_MANUAL_CAL = 2'b01,
        AMP_AUTO_CAL   = 2'b10
    } amp_mode_t;

endpackage : sense_ctrl_pkg

// *** phase_channel.sv ***
module phase_channel #(
    parameter int WINDOW_CYC = sense_ctrl_pkg::DRIVE_WINDOW_CYC,
    parameter int CAL_CYC    = sense_ctrl_pkg::AUTO_CAL_CYC
) (
    input  wire logic                      clk_i,
    input  wire logic                      rst_n_i,
    input  wire logic                      sense_fault_off_i,
    input  wire logic                      offset_trim_i,
    input  wire logic                      cal_mode_auto_i,
    input  wire logic                      sense_trip_i,
    input  wire logic                      gate_cmd_i,
    input  wire logic                      gate_on_i,
    output logic                           sense_fault_o,
    output logic                           gate_fault_o,
    output sense_ctrl_pkg::amp_mode_t      amp_mode_o,
    output logic                           cal_busy_o
);

    // ------------------------------------------------------------
    // local state
    // ------------------------------------------------------------
    logic [15:0] win_cnt_reg;
    logic [15:0] cal_cnt_reg;
    logic        trim_d_reg;

    // sense fault qualified by disable bit
    always_ff @(posedge clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
            sense_fault_o <= 1'b0;
        else
            sense_fault_o <= sense_trip_i & ~sense_fault_off_i;
    end

    // amplifier mode from trim bit and calibration mode
    always_ff @(posedge clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
            amp_mode_o <= sense_ctrl_pkg::AMP_NORMAL;
        else if (!offset_trim_i)
            amp_mode_o <= sense_ctrl_pkg::AMP_NORMAL;
        else if (cal_mode_auto_i)
            amp_mode_o <= sense_ctrl_pkg::AMP_AUTO_CAL;
        else
            amp_mode_o <= sense_ctrl_pkg::AMP_MANUAL_CAL;
    end

    // auto calibration routine runs on rising trim bit
    always_ff @(posedge clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            trim_d_reg  <= 1'b0;
            cal_cnt_reg <= 16'h0000;
            cal_busy_o  <= 1'b0;
        end
        else
        begin
            trim_d_reg <= offset_trim_i;
            if (offset_trim_i && !trim_d_reg && cal_mode_auto_i)
            begin
                cal_cnt_reg <= 16'(CAL_CYC);
                cal_busy_o  <= 1'b1;
            end
            else if (cal_cnt_reg != 16'h0000)
            begin
                cal_cnt_reg <= cal_cnt_reg - 16'h0001;
                cal_busy_o  <= (cal_cnt_reg != 16'h0001);
            end
            else
                cal_busy_o <= 1'b0;
        end
    end

    // gate drive window: fault if switch not on in time
    always_ff @(posedge clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            win_cnt_reg  <= 16'h0000;
            gate_fault_o <= 1'b0;
        end
        else if (!gate_cmd_i || gate_on_i)
        begin
            win_cnt_reg  <= 16'h0000;
            gate_fault_o <= 1'b0;
        end
        else if (win_cnt_reg == 16'(WINDOW_CYC - 1))
            gate_fault_o <= 1'b1;
        else
            win_cnt_reg <= win_cnt_reg + 16'h0001;
    end

endmodule : phase_channel

// *** sense_fault_cal_control.sv ***
// How it works
// - control register at 0x10, resets to zero
// - bit 5 disables phase C sense fault
// - bit 4 disables phase B sense fault
// - bit 3 disables phase A sense fault
// - bit 2 calibrates amplifier C per mode
// - bit 1 calibrates amplifier B per mode
// - bit 0 calibrates amplifier A per mode
// - serial: separate source and sink current registers
// - hardware variant: one pin sets both currents
// - gate fault when switch misses drive window
// - calibration mode 0 manual, 1 automatic
module sense_fault_cal_control #(
    parameter bit HW_VARIANT = 1'b0,
    parameter int WINDOW_CYC = sense_ctrl_pkg::DRIVE_WINDOW_CYC,
    parameter int CAL_CYC    = sense_ctrl_pkg::AUTO_CAL_CYC
) (
    input  wire logic                  clk_i,
    input  wire logic                  rst_n_i,
    input  wire logic                  wr_en_i,
    input  wire logic [7:0]            addr_i,
    input  wire logic [7:0]            wr_data_i,
    output logic      [7:0]            rd_data_o,
    input  wire logic                  cal_mode_auto_i,
    input  wire logic [7:0]            gate_source_reg_i,
    input  wire logic [7:0]            gate_sink_reg_i,
    input  wire logic [7:0]            gate_strength_pin_i,
    input  wire logic [2:0]            sense_trip_i,
    input  wire logic [2:0]            gate_cmd_i,
    input  wire logic [2:0]            gate_on_i,
    output logic      [7:0]            gate_source_current_o,
    output logic      [7:0]            gate_sink_current_o,
    output logic      [2:0]            sense_fault_o,
    output logic                       gate_fault_o,
    output logic      [2:0]            amp_short_o,
    output logic      [2:0]            amp_auto_o,
    output logic      [2:0]            cal_busy_o
);

    // ------------------------------------------------------------
    // control register
    // ------------------------------------------------------------
    logic [7:0] ctrl_reg;
    logic [7:0] ctrl_next;
    logic       ctrl_hit;
    logic       ctrl_write;

    // address decode shared by the write and read paths
    assign ctrl_hit   = (addr_i == sense_ctrl_pkg::CTRL_ADDR);
    assign ctrl_write = wr_en_i & ctrl_hit;

    // hold unless a write hits the control address
    always_comb
    begin
        if (ctrl_write)
            ctrl_next = wr_data_i;
        else
            ctrl_next = ctrl_reg;
    end

    // all eight bits are stored, reserved ones included
    always_ff @(posedge clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
            ctrl_reg <= sense_ctrl_pkg::CTRL_RESET;
        else
            ctrl_reg <= ctrl_next;
    end

    // ------------------------------------------------------------
    // read path
    // ------------------------------------------------------------
    logic [7:0] rd_next;

    // unmapped addresses read as zero
    always_comb
    begin
        if (ctrl_hit)
            rd_next = ctrl_reg;
        else
            rd_next = 8'h00;
    end

    // read data lags the address by one clock
    always_ff @(posedge clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
            rd_data_o <= 8'h00;
        else
            rd_data_o <= rd_next;
    end

    // ------------------------------------------------------------
    // register fields
    // ------------------------------------------------------------
    logic       phase_a_sense_fault_off;
    logic       phase_b_sense_fault_off;
    logic       phase_c_sense_fault_off;
    logic       amp_a_offset_trim;
    logic       amp_b_offset_trim;
    logic       amp_c_offset_trim;

    // name each control bit; the top two only read back
    assign phase_a_sense_fault_off = ctrl_reg[sense_ctrl_pkg::SEN_A_BIT];
    assign phase_b_sense_fault_off = ctrl_reg[sense_ctrl_pkg::SEN_B_BIT];
    assign phase_c_sense_fault_off = ctrl_reg[sense_ctrl_pkg::SEN_C_BIT];
    assign amp_a_offset_trim       = ctrl_reg[sense_ctrl_pkg::CAL_A_BIT];
    assign amp_b_offset_trim       = ctrl_reg[sense_ctrl_pkg::CAL_B_BIT];
    assign amp_c_offset_trim       = ctrl_reg[sense_ctrl_pkg::CAL_C_BIT];

    // ------------------------------------------------------------
    // gate current selection
    // ------------------------------------------------------------
    logic [7:0] source_sel;
    logic [7:0] sink_sel;

    // one pin sets both currents on the pin variant
    always_comb
    begin
        if (HW_VARIANT)
        begin
            source_sel = gate_strength_pin_i;
            sink_sel   = gate_strength_pin_i;
        end
        else
        begin
            source_sel = gate_source_reg_i;
            sink_sel   = gate_sink_reg_i;
        end
    end

    // registered current settings
    always_ff @(posedge clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            gate_source_current_o <= sense_ctrl_pkg::GATE_CUR_RESET;
            gate_sink_current_o   <= sense_ctrl_pkg::GATE_CUR_RESET;
        end
        else
        begin
            gate_source_current_o <= source_sel;
            gate_sink_current_o   <= sink_sel;
        end
    end

    // ------------------------------------------------------------
    // per-phase channels
    // ------------------------------------------------------------
    logic [2:0] gate_fault_ph;
    sense_ctrl_pkg::amp_mode_t mode_ph [3];

    // phase a channel
    phase_channel #(
        .WINDOW_CYC (WINDOW_CYC),
        .CAL_CYC    (CAL_CYC)
    ) u_phase_a (
        .clk_i             (clk_i),
        .rst_n_i           (rst_n_i),
        .sense_fault_off_i (phase_a_sense_fault_off),
        .offset_trim_i     (amp_a_offset_trim),
        .cal_mode_auto_i   (cal_mode_auto_i),
        .sense_trip_i      (sense_trip_i[0]),
        .gate_cmd_i        (gate_cmd_i[0]),
        .gate_on_i         (gate_on_i[0]),
        .sense_fault_o     (sense_fault_o[0]),
        .gate_fault_o      (gate_fault_ph[0]),
        .amp_mode_o        (mode_ph[0]),
        .cal_busy_o        (cal_busy_o[0])
    );

    // phase b channel
    phase_channel #(
        .WINDOW_CYC (WINDOW_CYC),
        .CAL_CYC    (CAL_CYC)
    ) u_phase_b (
        .clk_i             (clk_i),
        .rst_n_i           (rst_n_i),
        .sense_fault_off_i (phase_b_sense_fault_off),
        .offset_trim_i     (amp_b_offset_trim),
        .cal_mode_auto_i   (cal_mode_auto_i),
        .sense_trip_i      (sense_trip_i[1]),
        .gate_cmd_i        (gate_cmd_i[1]),
        .gate_on_i         (gate_on_i[1]),
        .sense_fault_o     (sense_fault_o[1]),
        .gate_fault_o      (gate_fault_ph[1]),
        .amp_mode_o        (mode_ph[1]),
        .cal_busy_o        (cal_busy_o[1])
    );

    // phase c channel
    phase_channel #(
        .WINDOW_CYC (WINDOW_CYC),
        .CAL_CYC    (CAL_CYC)
    ) u_phase_c (
        .clk_i             (clk_i),
        .rst_n_i           (rst_n_i),
        .sense_fault_off_i (phase_c_sense_fault_off),
        .offset_trim_i     (amp_c_offset_trim),
        .cal_mode_auto_i   (cal_mode_auto_i),
        .sense_trip_i      (sense_trip_i[2]),
        .gate_cmd_i        (gate_cmd_i[2]),
        .gate_on_i         (gate_on_i[2]),
        .sense_fault_o     (sense_fault_o[2]),
        .gate_fault_o      (gate_fault_ph[2]),
        .amp_mode_o        (mode_ph[2]),
        .cal_busy_o        (cal_busy_o[2])
    );

    // ------------------------------------------------------------
    // amplifier mode outputs
    // ------------------------------------------------------------
    // inputs shorted for manual trim, internal routine for auto trim
    assign amp_short_o[0] = (mode_ph[0] == sense_ctrl_pkg::AMP_MANUAL_CAL);
    assign amp_short_o[1] = (mode_ph[1] == sense_ctrl_pkg::AMP_MANUAL_CAL);
    assign amp_short_o[2] = (mode_ph[2] == sense_ctrl_pkg::AMP_MANUAL_CAL);
    assign amp_auto_o[0]  = (mode_ph[0] == sense_ctrl_pkg::AMP_AUTO_CAL);
    assign amp_auto_o[1]  = (mode_ph[1] == sense_ctrl_pkg::AMP_AUTO_CAL);
    assign amp_auto_o[2]  = (mode_ph[2] == sense_ctrl_pkg::AMP_AUTO_CAL);

    // ------------------------------------------------------------
    // gate fault summary
    // ------------------------------------------------------------
    // any phase gate fault
    assign gate_fault_o = |gate_fault_ph;

endmodule : sense_fault_cal_control

// *** sense_fault_cal_control_assertions.sv ***
module sense_fault_cal_control_chk #(
    parameter bit HW_VARIANT = 1'b0,
    parameter int WINDOW_CYC = sense_ctrl_pkg::DRIVE_WINDOW_CYC
) (
    input wire logic       clk_i,
    input wire logic       rst_n_i,
    input wire logic       wr_en_i,
    input wire logic [7:0] addr_i,
    input wire logic [7:0] wr_data_i,
    input wire logic [7:0] rd_data_o,
    input wire logic       cal_mode_auto_i,
    input wire logic [7:0] gate_source_reg_i,
    input wire logic [7:0] gate_sink_reg_i,
    input wire logic [7:0] gate_strength_pin_i,
    input wire logic [2:0] sense_trip_i,
    input wire logic [2:0] gate_cmd_i,
    input wire logic [2:0] gate_on_i,
    input wire logic [7:0] gate_source_current_o,
    input wire logic [7:0] gate_sink_current_o,
    input wire logic [2:0] sense_fault_o,
    input wire logic       gate_fault_o,
    input wire logic [2:0] amp_short_o,
    input wire logic [2:0] amp_auto_o
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [7:0] sh_reg;
    logic [7:0] cnt_reg;
    logic       up_reg;
    // ------------------------------------------------------------
    // shadow register, phase a stuck counter, live flag
    // ------------------------------------------------------------
    always_ff @(posedge clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            sh_reg  <= sense_ctrl_pkg::CTRL_RESET;
            cnt_reg <= 8'h00;
            up_reg  <= 1'b0;
        end
        else
        begin
            if (wr_en_i && addr_i == sense_ctrl_pkg::CTRL_ADDR)
                sh_reg <= wr_data_i;
            cnt_reg <= (gate_cmd_i[0] && !gate_on_i[0]) ?
                       ((cnt_reg == 8'hFF) ? cnt_reg : cnt_reg + 8'h01) : 8'h00;
            up_reg  <= 1'b1;
        end
    end
    default clocking @(posedge clk_i); endclocking
    default disable iff (!rst_n_i);
    sequence s_calm;
        up_reg && $stable(sh_reg) && $stable(cal_mode_auto_i);
    endsequence
    AST_RD_CTRL: assert property (up_reg && addr_i == sense_ctrl_pkg::CTRL_ADDR
        |=> rd_data_o == $past(sh_reg)) else $error("read data differs from control");
    AST_RD_ZERO: assert property (addr_i != sense_ctrl_pkg::CTRL_ADDR
        |=> rd_data_o == 8'h00) else $error("unmapped read not zero");
    AST_SEN_C: assert property (up_reg |-> sense_fault_o[2] ==
        ($past(sense_trip_i[2]) && !$past(sh_reg[5]))) else $error("phase c fault wrong");
    AST_SEN_B: assert property (up_reg |-> sense_fault_o[1] ==
        ($past(sense_trip_i[1]) && !$past(sh_reg[4]))) else $error("phase b fault wrong");
    AST_SEN_A: assert property (up_reg |-> sense_fault_o[0] ==
        ($past(sense_trip_i[0]) && !$past(sh_reg[3]))) else $error("phase a fault wrong");
    AST_SHORT: assert property (s_calm |=> amp_short_o ==
        ($past(sh_reg[2:0]) & {3{!$past(cal_mode_auto_i)}})) else $error("short wrong");
    AST_AUTO: assert property (s_calm |=> amp_auto_o ==
        ($past(sh_reg[2:0]) & {3{$past(cal_mode_auto_i)}})) else $error("auto wrong");
    AST_CUR: assert property (up_reg |-> gate_source_current_o ==
        $past(HW_VARIANT ? gate_strength_pin_i : gate_source_reg_i) && gate_sink_current_o
        == $past(HW_VARIANT ? gate_strength_pin_i : gate_sink_reg_i)) else $error("current");
    AST_GF_SET: assert property (cnt_reg >= WINDOW_CYC |-> gate_fault_o)
        else $error("gate fault missing");
    AST_GF_CLR: assert property (up_reg && $past(gate_cmd_i & ~gate_on_i) == 3'h0
        |-> !gate_fault_o) else $error("gate fault without cause");
endmodule : sense_fault_cal_control_chk
bind sense_fault_cal_control sense_fault_cal_control_chk #(.HW_VARIANT(HW_VARIANT),
    .WINDOW_CYC(WINDOW_CYC)) chk (.*);

// *** sense_fault_cal_control_tb_top.sv ***
module sense_fault_cal_control_tb_top;
    timeunit 1ns;
    timeprecision 1ps;
`define CHK(n, e, g) begin n_compared++; if ((g) !== (e)) begin err_total++; \
    $display("BAD %s exp %h got %h", n, e, g); end end
    logic       clk_i = 1'b0, rst_n_i = 1'b0, wr_en_i = 1'b0, cal_mode_auto_i = 1'b0;
    logic [7:0] addr_i = 8'h10, wr_data_i = 8'h00, rd_data_o;
    logic [7:0] gate_source_reg_i = 8'h00, gate_sink_reg_i = 8'h00;
    logic [7:0] gate_strength_pin_i = 8'h99, gate_source_current_o, gate_sink_current_o;
    logic [2:0] sense_trip_i = 3'h0, gate_cmd_i = 3'h0, gate_on_i = 3'h0;
    logic [2:0] sense_fault_o, amp_short_o, amp_auto_o, cal_busy_o;
    logic       gate_fault_o;
    logic [7:0] pin_source, pin_sink;
    int         err_total = 0, n_compared = 0, cyc_cnt = 0;
    logic [27:0] r;
    // ctrl, mode, trip, fault, short, auto
    logic [27:0] rows [8] = '{28'h000_7700, 28'h080_7600, 28'h100_7500, 28'h200_7300,
                              28'h070_0070, 28'hC50_7750, 28'h3A0_7020, 28'h071_7707};
    sense_fault_cal_control #(.HW_VARIANT(1'b0), .WINDOW_CYC(5), .CAL_CYC(4)) dut (.*);
    // pin variant: only its current outputs are watched
    sense_fault_cal_control #(.HW_VARIANT(1'b1), .WINDOW_CYC(5), .CAL_CYC(4)) dut_pin (
        .clk_i(clk_i), .rst_n_i(rst_n_i), .wr_en_i(wr_en_i), .addr_i(addr_i),
        .wr_data_i(wr_data_i), .rd_data_o(), .cal_mode_auto_i(cal_mode_auto_i),
        .gate_source_reg_i(gate_source_reg_i), .gate_sink_reg_i(gate_sink_reg_i),
        .gate_strength_pin_i(gate_strength_pin_i), .sense_trip_i(sense_trip_i),
        .gate_cmd_i(gate_cmd_i), .gate_on_i(gate_on_i), .gate_source_current_o(pin_source),
        .gate_sink_current_o(pin_sink), .sense_fault_o(), .gate_fault_o(), .amp_short_o(),
        .amp_auto_o(), .cal_busy_o());
    // clock and hang guard
    always #10 clk_i = ~clk_i;
    always @(posedge clk_i)
    begin
        cyc_cnt++;
        if (cyc_cnt == 2000)
        begin
            err_total++;
            report_and_stop();
        end
    end
    // ------------------------------------------------------------
    // tasks
    // ------------------------------------------------------------
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge clk_i);
        wr_en_i = 1'b1;
        addr_i = a;
        wr_data_i = d;
    endtask : wr
    task automatic idle(input int n);
        @(negedge clk_i);
        wr_en_i = 1'b0;
        repeat (n) @(negedge clk_i);
    endtask : idle
    task report_and_stop;
        $display("compared %0d mismatches %0d", n_compared, err_total);
        if (err_total == 0 && n_compared > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask : report_and_stop
    // main sequence
    initial
    begin
        repeat (5) @(negedge clk_i);
        rst_n_i = 1'b1;
        idle(2);
        `CHK("rd reset", 8'h00, rd_data_o)
        $display("test reset done");
        for (int i = 0; i < 8; i++)
        begin
            r = rows[i];
            wr(8'h10, r[27:20]);
            cal_mode_auto_i = r[16];
            sense_trip_i = r[14:12];
            idle(3);
            `CHK("rd", r[27:20], rd_data_o)
            `CHK("fault", r[10:8], sense_fault_o)
            `CHK("short", r[6:4], amp_short_o)
            `CHK("auto", r[2:0], amp_auto_o)
        end
        $display("test rows done");
        wr(8'h10, 8'h08);
        wr(8'h11, 8'hFF);
        idle(2);
        `CHK("rd unmapped", 8'h00, rd_data_o)
        addr_i = 8'h10;
        repeat (2) @(negedge clk_i);
        `CHK("rd kept", 8'h08, rd_data_o)
        `CHK("fault a off", 3'h6, sense_fault_o)
        wr(8'h10, 8'h00);
        idle(1);
        wr(8'h10, 8'h01);
        idle(2);
        `CHK("busy", 3'h1, cal_busy_o)
        repeat (2) @(negedge clk_i);
        `CHK("busy last", 3'h1, cal_busy_o)
        @(negedge clk_i);
        `CHK("busy end", 3'h0, cal_busy_o)
        $display("test calibration done");
        gate_source_reg_i = 8'h3C;
        gate_sink_reg_i = 8'h5A;
        repeat (2) @(negedge clk_i);
        `CHK("source", 8'h3C, gate_source_current_o)
        `CHK("sink", 8'h5A, gate_sink_current_o)
        `CHK("pin source", 8'h99, pin_source)
        `CHK("pin sink", 8'h99, pin_sink)
        for (int k = 0; k < 3; k++)
        begin
            @(negedge clk_i);
            gate_cmd_i = 3'h1 << k;
            repeat (4) @(negedge clk_i);
            `CHK("gate early", 1'b0, gate_fault_o)
            @(negedge clk_i);
            `CHK("gate fault", 1'b1, gate_fault_o)
            gate_on_i = gate_cmd_i;
            repeat (2) @(negedge clk_i);
            `CHK("gate clear", 1'b0, gate_fault_o)
            gate_cmd_i = 3'h0;
            gate_on_i = 3'h0;
        end
        $display("test gate done");
        // mid-run reset returns the register and amp_auto_o to zero and unmasks all three sense faults
        wr(8'h10, 8'h3F);
        idle(2);
        `CHK("fault before reset", 3'h0, sense_fault_o)
        `CHK("auto before reset", 3'h7, amp_auto_o)
        rst_n_i = 1'b0;
        @(negedge clk_i);
        `CHK("rd in reset", 8'h00, rd_data_o)
        `CHK("auto in reset", 3'h0, amp_auto_o)
        rst_n_i = 1'b1;
        repeat (2) @(negedge clk_i);
        `CHK("rd after reset", 8'h00, rd_data_o)
        `CHK("fault after reset", 3'h7, sense_fault_o)
        `CHK("auto after reset", 3'h0, amp_auto_o)
        $display("test mid reset done");
        report_and_stop();
    end
endmodule : sense_fault_cal_control_tb_top
